// [tmr_defines.svh]
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
// register byte addresses
`define TMR_ADDR_COUNT 4'h0
`define TMR_ADDR_COMPARE 4'h4
`define TMR_ADDR_CTRL 4'h8
`define TMR_ADDR_FLAG 4'hC
// second bank selected by address bit 4
`define TMR_ADDR_MASK 5'h10
`define TMR_ADDR_FORCE 5'h14
// field positions
`define TMR_FLAG_OVF 0
`define TMR_FLAG_CMP 1
// control: [2:0] clock select, [4:3] mode, [6:5] output action
`define TMR_CTRL_CS_LSB 0
`define TMR_CTRL_WGM_LSB 3
`define TMR_CTRL_COM_LSB 5
// limits
`define TMR_BOTTOM 8'h00
`define TMR_MAX 8'hFF
`define TMR_RESET_BYTE 8'h00
`endif

// [tmr_pkg.sv]
`default_nettype none
package tmr_pkg;
  // clock select codes
  typedef enum logic [2:0] {
    TMR_CS_STOP = 3'h0,
    TMR_CS_DIV1 = 3'h1,
    TMR_CS_DIV8 = 3'h2,
    TMR_CS_DIV64 = 3'h3,
    TMR_CS_DIV256 = 3'h4,
    TMR_CS_DIV1024 = 3'h5,
    TMR_CS_EXT_FALL = 3'h6,
    TMR_CS_EXT_RISE = 3'h7
  } tmr_cs_t;
  // operating modes
  typedef enum logic [1:0] {
    TMR_WGM_NORMAL = 2'h0,
    TMR_WGM_PCPWM = 2'h1,
    TMR_WGM_CTC = 2'h2,
    TMR_WGM_FAST = 2'h3
  } tmr_wgm_t;
  // control register fields
  typedef struct packed {
    logic unused;
    logic [1:0] com;
    tmr_wgm_t wgm;
    tmr_cs_t cs;
  } tmr_ctrl_t;
  // sticky event flags
  typedef struct packed {
    logic cmp;
    logic ovf;
  } tmr_flags_t;
endpackage
`default_nettype wire

// [tmr_core.sv]
`include "tmr_defines.svh"
`default_nettype none
module tmr_core #(
  parameter int PRESCALE_W = 10 // prescaler width
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [4:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic wb_err_o, // unmapped access
  input wire logic ext_count_pin_i, // external count pin
  input wire logic cmp_irq_ack_i, // compare interrupt serviced
  input wire logic ovf_irq_ack_i, // overflow interrupt serviced
  output logic compare_out_pin_o, // waveform output
  output logic cmp_irq_o, // masked compare request
  output logic ovf_irq_o, // masked overflow request
  output logic bottom_o, // counter at zero
  output logic max_o // counter at 0xFF
);
  logic [7:0] counter_value_q;
  logic [7:0] compare_value_q; // compare actually used
  logic [7:0] compare_buf_q; // software copy
  tmr_pkg::tmr_ctrl_t ctrl_q;
  tmr_pkg::tmr_flags_t flags_q;
  tmr_pkg::tmr_flags_t mask_q;
  logic [PRESCALE_W-1:0] presc_q;
  logic [PRESCALE_W-1:0] presc_d;
  logic [2:0] ext_sync_q; // two sync stages plus edge history
  logic tick;
  logic down_q;
  logic block_q;
  logic match;
  logic wave_q;
  logic [7:0] top;
  logic pwm_mode;
  logic bus_req;
  logic wr;
  logic wr_count;
  logic wr_flag;
  logic wr_force;
  logic mapped;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = (wb_adr_i[1:0] == 2'h0) && (wb_adr_i <= `TMR_ADDR_FORCE);
  assign wr = bus_req && mapped && wb_we_i && wb_sel_i[0];
  assign wr_count = wr && (wb_adr_i == {1'b0, `TMR_ADDR_COUNT});
  assign wr_flag = wr && (wb_adr_i == {1'b0, `TMR_ADDR_FLAG});
  assign wr_force = wr && (wb_adr_i == `TMR_ADDR_FORCE);
  assign pwm_mode = ctrl_q.wgm inside {tmr_pkg::TMR_WGM_PCPWM, tmr_pkg::TMR_WGM_FAST};
  // top follows compare only in clear-on-match mode
  assign top = (ctrl_q.wgm == tmr_pkg::TMR_WGM_CTC) ? compare_value_q : `TMR_MAX;
  // continuous comparator, independent of software
  assign match = (counter_value_q == compare_value_q);

  // free-running prescaler
  assign presc_d = presc_q + {{(PRESCALE_W-1){1'b0}}, 1'b1};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_d;
    end
  end

  // pin passes two flops before the edge detector looks at it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_sync_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_count_pin_i};
    end
  end

  // tick source and edge selection; a tick is a one-cycle enable
  always_comb begin
    unique case (ctrl_q.cs)
      tmr_pkg::TMR_CS_STOP: tick = 1'b0;
      tmr_pkg::TMR_CS_DIV1: tick = 1'b1;
      tmr_pkg::TMR_CS_DIV8: tick = (presc_q[2:0] == 3'h7);
      tmr_pkg::TMR_CS_DIV64: tick = (presc_q[5:0] == 6'h3F);
      tmr_pkg::TMR_CS_DIV256: tick = (presc_q[7:0] == 8'hFF);
      tmr_pkg::TMR_CS_DIV1024: tick = (presc_q == '1);
      tmr_pkg::TMR_CS_EXT_FALL: tick = ext_sync_q[2] && !ext_sync_q[1];
      tmr_pkg::TMR_CS_EXT_RISE: tick = !ext_sync_q[2] && ext_sync_q[1];
    endcase
  end

  // counter: cpu write wins over count and clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_value_q <= `TMR_RESET_BYTE;
      down_q <= 1'b0;
    end else if (wr_count) begin
      counter_value_q <= wb_dat_i[7:0];
    end else if (tick) begin
      if (ctrl_q.wgm == tmr_pkg::TMR_WGM_PCPWM) begin
        // phase correct: up to max, then down to bottom
        if (!down_q && counter_value_q == `TMR_MAX) begin
          down_q <= 1'b1;
          counter_value_q <= counter_value_q - 8'h01;
        end else if (down_q && counter_value_q == `TMR_BOTTOM) begin
          down_q <= 1'b0;
          counter_value_q <= counter_value_q + 8'h01;
        end else if (down_q) begin
          counter_value_q <= counter_value_q - 8'h01;
        end else begin
          counter_value_q <= counter_value_q + 8'h01;
        end
      end else if (counter_value_q == top) begin
        counter_value_q <= `TMR_BOTTOM;
        down_q <= 1'b0;
      end else begin
        counter_value_q <= counter_value_q + 8'h01;
        down_q <= 1'b0;
      end
    end
  end

  // a counter write blocks the match seen at the following tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_q <= 1'b0;
    end else if (wr_count) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // compare buffer: pwm updates only at max so pulses stay whole
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_buf_q <= `TMR_RESET_BYTE;
      compare_value_q <= `TMR_RESET_BYTE;
    end else begin
      if (wr && wb_adr_i == {1'b0, `TMR_ADDR_COMPARE}) begin
        compare_buf_q <= wb_dat_i[7:0];
        if (!pwm_mode) begin
          compare_value_q <= wb_dat_i[7:0];
        end
      end
      if (pwm_mode && tick && (counter_value_q == `TMR_MAX)) begin
        compare_value_q <= compare_buf_q;
      end
    end
  end

  // sticky flags: hardware set beats the clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else begin
      if (tick && match && !block_q && !wr_count) begin
        flags_q.cmp <= 1'b1;
      end else if ((wr_flag && wb_dat_i[`TMR_FLAG_CMP]) || cmp_irq_ack_i) begin
        flags_q.cmp <= 1'b0;
      end
      if (tick && !wr_count && ((ctrl_q.wgm == tmr_pkg::TMR_WGM_PCPWM) ?
          (down_q && counter_value_q == `TMR_BOTTOM) : (counter_value_q == top))) begin
        flags_q.ovf <= 1'b1;
      end else if ((wr_flag && wb_dat_i[`TMR_FLAG_OVF]) || ovf_irq_ack_i) begin
        flags_q.ovf <= 1'b0;
      end
    end
  end

  // waveform generator; force only acts outside pwm modes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wave_q <= 1'b0;
    end else if ((tick && match && !block_q && !wr_count) || (wr_force && !pwm_mode)) begin
      unique case (ctrl_q.com)
        2'h0: wave_q <= wave_q;
        2'h1: wave_q <= !wave_q;
        2'h2: wave_q <= down_q;
        2'h3: wave_q <= !down_q;
      endcase
    end else if (pwm_mode && ctrl_q.com[1] && tick && counter_value_q == `TMR_MAX &&
                 ctrl_q.wgm == tmr_pkg::TMR_WGM_FAST) begin
      wave_q <= !ctrl_q.com[0];
    end
  end

  // control and mask registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= '0;
      mask_q <= '0;
    end else begin
      if (wr && wb_adr_i == {1'b0, `TMR_ADDR_CTRL}) begin
        ctrl_q <= wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == `TMR_ADDR_MASK) begin
        mask_q <= wb_dat_i[1:0];
      end
    end
  end

  // bus answer one cycle after request; outputs all from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req && mapped;
      wb_err_o <= bus_req && !mapped;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && mapped && !wb_we_i) begin
        unique case (wb_adr_i)
          {1'b0, `TMR_ADDR_COUNT}: wb_dat_o[7:0] <= counter_value_q;
          {1'b0, `TMR_ADDR_COMPARE}: wb_dat_o[7:0] <= compare_buf_q;
          {1'b0, `TMR_ADDR_CTRL}: wb_dat_o[7:0] <= ctrl_q;
          {1'b0, `TMR_ADDR_FLAG}: wb_dat_o[1:0] <= flags_q;
          `TMR_ADDR_MASK: wb_dat_o[1:0] <= mask_q;
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      compare_out_pin_o <= 1'b0;
      cmp_irq_o <= 1'b0;
      ovf_irq_o <= 1'b0;
      bottom_o <= 1'b0;
      max_o <= 1'b0;
    end else begin
      compare_out_pin_o <= wave_q;
      cmp_irq_o <= flags_q.cmp && mask_q.cmp && !cmp_irq_ack_i;
      ovf_irq_o <= flags_q.ovf && mask_q.ovf && !ovf_irq_ack_i;
      bottom_o <= (counter_value_q == `TMR_BOTTOM);
      max_o <= (counter_value_q == `TMR_MAX);
    end
  end
endmodule
`default_nettype wire

// [tmr_core_sva.sv]
`default_nettype none
module tmr_core_sva (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic wb_err_o, // error
  input wire logic cmp_irq_ack_i, // compare serviced
  input wire logic ovf_irq_ack_i, // overflow serviced
  input wire logic cmp_irq_o, // compare request
  input wire logic ovf_irq_o, // overflow request
  input wire logic bottom_o, // at zero
  input wire logic max_o // at 0xff
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a fresh request and its single-cycle answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_answer;
    (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
  endsequence
  // flags are sticky unless serviced or written, with one cycle of margin for the mask stage
  sequence s_quiet(ack);
    !ack && !$past(ack) && !(wb_cyc_i && wb_stb_i && wb_we_i) && !$past(wb_cyc_i && wb_we_i);
  endsequence
  a_req_answer: assert property (s_req |=> s_answer)
    else $error("request not answered in one cycle");
  a_idle_silent: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data above bit 7 not zero");
  a_reset_quiet: assert property ($fell(rst_i) |-> !cmp_irq_o && !ovf_irq_o)
    else $error("request active after reset");
  a_bm_excl: assert property (!(bottom_o && max_o))
    else $error("bottom and max together");
  a_cmp_sticky: assert property (cmp_irq_o ##0 s_quiet(cmp_irq_ack_i) |=> cmp_irq_o)
    else $error("compare request dropped by itself");
  a_ovf_sticky: assert property (ovf_irq_o ##0 s_quiet(ovf_irq_ack_i) |=> ovf_irq_o)
    else $error("overflow request dropped by itself");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule
bind tmr_core tmr_core_sva chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o,
  .wb_ack_o, .wb_err_o, .cmp_irq_ack_i, .ovf_irq_ack_i, .cmp_irq_o, .ovf_irq_o, .bottom_o, .max_o);
`default_nettype wire

// [tb_top.sv]
`include "tmr_defines.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic ext_count_pin_i = 1'b0, cmp_irq_ack_i = 1'b0, ovf_irq_ack_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, wb_err_o, compare_out_pin_o, cmp_irq_o, ovf_irq_o, bottom_o, max_o, er;
  int n_mismatch = 0, compares = 0, cycles = 0;
  tmr_core uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .ext_count_pin_i, .cmp_irq_ack_i,
    .ovf_irq_ack_i, .compare_out_pin_o, .cmp_irq_o, .ovf_irq_o, .bottom_o, .max_o);
  // free-running 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one classic cycle, held until ack or err is sampled, then one idle cycle
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, 24'h00_0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    er = wb_err_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic ctrl(input logic [2:0] cs, input logic [1:0] mode);
    xfer(1'b1, `TMR_ADDR_CTRL, {3'b000, mode, cs});
  endtask
  logic [4:0] regs [4] = '{`TMR_ADDR_COUNT, `TMR_ADDR_COMPARE, `TMR_ADDR_FLAG, `TMR_ADDR_MASK};
  logic [7:0] start [2] = '{8'h30, 8'h2F};
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (regs[i]) begin
      xfer(1'b0, regs[i], 8'h00);
      chk("reset reg", 32'h0000_0000, rd);
    end
    chk("bottom", 32'h0000_0001, bottom_o);
    xfer(1'b0, 5'h18, 8'h00);
    chk("unmapped err", 32'h0000_0001, er);
    xfer(1'b1, `TMR_ADDR_COMPARE, 8'hA5);
    xfer(1'b0, `TMR_ADDR_COMPARE, 8'h00);
    chk("compare rw", 32'h0000_00A5, rd);
    xfer(1'b1, `TMR_ADDR_COUNT, 8'hFF);
    repeat (20) @(posedge clk_i);
    chk("max", 32'h0000_0001, max_o);
    xfer(1'b0, `TMR_ADDR_COUNT, 8'h00);
    chk("stopped count", 32'h0000_00FF, rd);
    $display("test registers done");
    // overflow from 0xf8 in normal mode
    xfer(1'b1, `TMR_ADDR_COUNT, 8'hF8);
    ctrl(tmr_pkg::TMR_CS_DIV1, tmr_pkg::TMR_WGM_NORMAL);
    repeat (20) @(posedge clk_i);
    ctrl(tmr_pkg::TMR_CS_STOP, tmr_pkg::TMR_WGM_NORMAL);
    xfer(1'b0, `TMR_ADDR_FLAG, 8'h00);
    chk("ovf flag", 32'h0000_0001, rd & 32'h0000_0001);
    chk("ovf masked", 32'h0000_0000, ovf_irq_o);
    xfer(1'b1, `TMR_ADDR_FLAG, 8'h03);
    xfer(1'b0, `TMR_ADDR_FLAG, 8'h00);
    chk("flag cleared", 32'h0000_0000, rd);
    $display("test overflow done");
    // clear-on-match keeps the count at or below compare
    xfer(1'b1, `TMR_ADDR_COMPARE, 8'h20);
    xfer(1'b1, `TMR_ADDR_MASK, 8'h02);
    ctrl(tmr_pkg::TMR_CS_DIV1, tmr_pkg::TMR_WGM_CTC);
    repeat (100) @(posedge clk_i);
    xfer(1'b0, `TMR_ADDR_COUNT, 8'h00);
    chk("ctc range", 32'h0000_0001, rd <= 32'h0000_0020);
    ctrl(tmr_pkg::TMR_CS_STOP, tmr_pkg::TMR_WGM_CTC);
    chk("cmp irq", 32'h0000_0001, cmp_irq_o);
    cmp_irq_ack_i <= 1'b1;
    @(posedge clk_i);
    cmp_irq_ack_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("cmp serviced", 32'h0000_0000, cmp_irq_o);
    $display("test ctc done");
    // a counter write blocks the match of the following tick only
    foreach (start[i]) begin
      xfer(1'b1, `TMR_ADDR_COMPARE, 8'h30);
      xfer(1'b1, `TMR_ADDR_COUNT, start[i]);
      xfer(1'b1, `TMR_ADDR_FLAG, 8'h03);
      ctrl(tmr_pkg::TMR_CS_DIV1, tmr_pkg::TMR_WGM_NORMAL);
      repeat (4) @(posedge clk_i);
      ctrl(tmr_pkg::TMR_CS_STOP, tmr_pkg::TMR_WGM_NORMAL);
      xfer(1'b0, `TMR_ADDR_FLAG, 8'h00);
      chk("blocked match", {30'h0, i == 1, 1'b0}, rd & 32'h0000_0002);
    end
    $display("test blocking done");
    // five pin edges counted for each chosen edge
    for (int c = 6; c < 8; c++) begin
      xfer(1'b1, `TMR_ADDR_COUNT, 8'h00);
      ctrl(c[2:0], tmr_pkg::TMR_WGM_NORMAL);
      repeat (10) begin
        ext_count_pin_i <= ~ext_count_pin_i;
        repeat (4) @(posedge clk_i);
      end
      repeat (6) @(posedge clk_i);
      ctrl(tmr_pkg::TMR_CS_STOP, tmr_pkg::TMR_WGM_NORMAL);
      xfer(1'b0, `TMR_ADDR_COUNT, 8'h00);
      chk("pin count", 32'h0000_0005, rd);
    end
    $display("test pin done");
    // pwm compare writes stay in the buffer until the count reaches max
    ctrl(tmr_pkg::TMR_CS_STOP, tmr_pkg::TMR_WGM_PCPWM);
    xfer(1'b1, `TMR_ADDR_COMPARE, 8'h40);
    xfer(1'b1, `TMR_ADDR_COUNT, 8'h3F);
    xfer(1'b1, `TMR_ADDR_FLAG, 8'h03);
    ctrl(tmr_pkg::TMR_CS_DIV1, tmr_pkg::TMR_WGM_PCPWM);
    repeat (4) @(posedge clk_i);
    ctrl(tmr_pkg::TMR_CS_STOP, tmr_pkg::TMR_WGM_PCPWM);
    xfer(1'b0, `TMR_ADDR_FLAG, 8'h00);
    chk("pwm held compare", 32'h0000_0000, rd & 32'h0000_0002);
    ctrl(tmr_pkg::TMR_CS_DIV1, tmr_pkg::TMR_WGM_FAST);
    repeat (300) @(posedge clk_i);
    ctrl(tmr_pkg::TMR_CS_STOP, tmr_pkg::TMR_WGM_FAST);
    xfer(1'b0, `TMR_ADDR_FLAG, 8'h00);
    chk("pwm loaded compare", 32'h0000_0002, rd & 32'h0000_0002);
    $display("test pwm done");
    // unmasked overflow from the divide-by-8 tick reaches its request pin
    xfer(1'b1, `TMR_ADDR_MASK, 8'h01);
    xfer(1'b1, `TMR_ADDR_COUNT, 8'hFF);
    xfer(1'b1, `TMR_ADDR_FLAG, 8'h03);
    ctrl(tmr_pkg::TMR_CS_DIV8, tmr_pkg::TMR_WGM_NORMAL);
    repeat (20) @(posedge clk_i);
    ctrl(tmr_pkg::TMR_CS_STOP, tmr_pkg::TMR_WGM_NORMAL);
    chk("ovf irq", 32'h0000_0001, ovf_irq_o);
    // forced match toggles the waveform pin outside pwm modes
    xfer(1'b1, `TMR_ADDR_CTRL, 8'h20);
    xfer(1'b1, `TMR_ADDR_FORCE, 8'h01);
    chk("forced pin", 32'h0000_0001, compare_out_pin_o);
    xfer(1'b1, `TMR_ADDR_FORCE, 8'h01);
    chk("forced pin back", 32'h0000_0000, compare_out_pin_o);
    $display("test outputs done");
    final_report();
  end
endmodule
`default_nettype wire
